// *** hw/standard_timer_output_and_clear_control.sv ***
/*
  Ten-bit standard timer with compare, PWM and single-pulse pin output,
  selectable counter clear source and an AXI4-Lite register slave.
  Assumes one 100 MHz clock, a synchronous active-low reset and software
  that stops the timer before changing mode or pin action.
*/
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "timer_cfg.svh"
module standard_timer_output_and_clear_control
  import timer_pkg::*;
#(
  parameter int unsigned TICK_DIV = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic timer_output_pin_a_o,
  output logic timer_output_pin_b_o,
  output logic timer_output_en_o
);

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `ADDR_RUN) || (a == `ADDR_CTL) || (a == `ADDR_CNT_LO) ||
                (a == `ADDR_CNT_HI) || (a == `ADDR_CMPA_LO) ||
                (a == `ADDR_CMPA_HI) || (a == `ADDR_CMPP);
  endfunction

  logic [15:0] div_reg;
  logic tick;
  logic run_reg;
  logic run_d_reg;
  logic run_rise;
  ctl_t ctl_reg;
  logic [9:0] cnt_reg;
  logic [9:0] cmpa_reg;
  logic [9:0] cmpp_reg;
  logic cmp_out_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic w_lane0_reg;
  logic wr_go;
  logic [9:0] period_val;
  logic [9:0] duty_val;
  logic [10:0] period_eff;
  logic match_a;
  logic match_p;
  logic pwm_end;
  logic pwm_act;
  logic cnt_clr;
  logic pulse_end;
  logic active;
  logic lvl;
  logic [31:0] rd_word;

  // Timer clock enable derived from the bus clock.
  assign tick = (div_reg == 16'(TICK_DIV - 1));

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || tick) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // AXI4-Lite write channel: address and data are taken independently.
  assign wr_go = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_axi_awready_o <= 1'b1;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      s_axi_awready_o <= 1'b0;
      aw_addr_reg <= s_axi_awaddr_i;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_awready_o <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_axi_wready_o <= 1'b1;
      w_data_reg <= 32'h0000_0000;
      w_lane0_reg <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      s_axi_wready_o <= 1'b0;
      w_data_reg <= s_axi_wdata_i;
      w_lane0_reg <= s_axi_wstrb_i[0];
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_wready_o <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= is_mapped(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  assign period_val = ctl_reg.period_duty_swap ? cmpa_reg : cmpp_reg;
  assign duty_val = ctl_reg.period_duty_swap ? cmpp_reg : cmpa_reg;
  // A zero period value lets the counter run its whole range.
  assign period_eff = (period_val == 10'h000) ? `PWM_FULL : {1'b0, period_val};

  assign match_a = (cnt_reg == cmpa_reg);
  assign match_p = (cmpp_reg != 10'h000) && (cnt_reg == cmpp_reg);
  assign pwm_end = ({1'b0, cnt_reg} == period_eff - 11'h001);
  assign pwm_act = ({1'b0, duty_val} >= period_eff) || (cnt_reg < duty_val);
  assign pulse_end = tick && run_reg && (ctl_reg.mode == MODE_PWM) &&
                     (ctl_reg.pin_action == 2'h3) && match_a;

  always_comb begin
    case (ctl_reg.mode)
      MODE_CMP, MODE_TMR: cnt_clr = ctl_reg.clear_source_select ? match_a : match_p;
      MODE_PWM: cnt_clr = pwm_end;
      default: cnt_clr = 1'b0;
    endcase
  end

  // Run bit: software sets and clears; a single pulse ends it on an A match.
  // A software write in the same cycle wins so a retrigger is never lost.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      run_reg <= 1'b0;
    end else if (wr_go && w_lane0_reg && aw_addr_reg == `ADDR_RUN) begin
      run_reg <= w_data_reg[`RUN_BIT];
    end else if (pulse_end) begin
      run_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      run_d_reg <= 1'b0;
    end else begin
      run_d_reg <= run_reg;
    end
  end

  assign run_rise = run_reg && !run_d_reg;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctl_reg <= ctl_t'(`CTL_RST);
    end else if (wr_go && w_lane0_reg && aw_addr_reg == `ADDR_CTL) begin
      ctl_reg <= ctl_t'(w_data_reg[7:0]);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cmpa_reg <= `CMP_RST;
    end else if (wr_go && w_lane0_reg && aw_addr_reg == `ADDR_CMPA_LO) begin
      cmpa_reg[7:0] <= w_data_reg[7:0];
    end else if (wr_go && w_lane0_reg && aw_addr_reg == `ADDR_CMPA_HI) begin
      cmpa_reg[9:8] <= w_data_reg[1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cmpp_reg <= `CMP_RST;
    end else if (wr_go && w_lane0_reg && aw_addr_reg == `ADDR_CMPP) begin
      cmpp_reg <= w_data_reg[9:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= `CNT_RST;
    end else if (tick && run_reg) begin
      cnt_reg <= cnt_clr ? `CNT_RST : cnt_reg + 10'h001;
    end
  end

  // Compare-mode pin state before inversion.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cmp_out_reg <= 1'b0;
    end else if (run_rise) begin
      cmp_out_reg <= ctl_reg.output_level_control;
    end else if (tick && run_reg && match_a && ctl_reg.mode == MODE_CMP) begin
      case (ctl_reg.pin_action)
        2'h1: cmp_out_reg <= 1'b0;
        2'h2: cmp_out_reg <= 1'b1;
        2'h3: cmp_out_reg <= !cmp_out_reg;
        default: cmp_out_reg <= cmp_out_reg;
      endcase
    end
  end

  // Pin action is sampled live; changing it while running gives glitches.
  always_comb begin
    case (ctl_reg.pin_action)
      2'h0: active = 1'b0;
      2'h1: active = 1'b1;
      2'h2: active = pwm_act;
      default: active = run_reg;
    endcase
  end

  always_comb begin
    case (ctl_reg.mode)
      MODE_CMP: lvl = cmp_out_reg ^ ctl_reg.output_invert;
      MODE_PWM: lvl = (active ? ctl_reg.output_level_control
                              : !ctl_reg.output_level_control) ^ ctl_reg.output_invert;
      default: lvl = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      timer_output_pin_a_o <= 1'b0;
      timer_output_pin_b_o <= 1'b0;
      timer_output_en_o <= 1'b0;
    end else begin
      timer_output_pin_a_o <= lvl;
      timer_output_pin_b_o <= lvl;
      timer_output_en_o <= (ctl_reg.mode == MODE_CMP) || (ctl_reg.mode == MODE_PWM);
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr_i)
      `ADDR_RUN: rd_word[`RUN_BIT] = run_reg;
      `ADDR_CTL: rd_word[7:0] = ctl_reg;
      `ADDR_CNT_LO: rd_word[7:0] = cnt_reg[7:0];
      `ADDR_CNT_HI: rd_word[1:0] = cnt_reg[9:8];
      `ADDR_CMPA_LO: rd_word[7:0] = cmpa_reg[7:0];
      `ADDR_CMPA_HI: rd_word[1:0] = cmpa_reg[9:8];
      `ADDR_CMPP: rd_word[9:0] = cmpp_reg;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_word;
      s_axi_rresp_o <= is_mapped(s_axi_araddr_i) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_cmp_step;
    tick && run_reg && (ctl_reg.mode == MODE_CMP || ctl_reg.mode == MODE_TMR);
  endsequence
  property p_clr_a;
    s_cmp_step and (ctl_reg.clear_source_select && match_a) |=> cnt_reg == 10'h000;
  endproperty
  a_clr_a: assert property (p_clr_a) else $error("counter not cleared on A match");
  property p_clr_p;
    s_cmp_step and (!ctl_reg.clear_source_select && match_p) |=> cnt_reg == 10'h000;
  endproperty
  a_clr_p: assert property (p_clr_p) else $error("counter not cleared on P match");
  property p_wrap;
    s_cmp_step and (!ctl_reg.clear_source_select && cmpp_reg == 10'h000 &&
                    cnt_reg == 10'h3ff) |=> cnt_reg == 10'h000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap at full range");
  property p_cap_ignore;
    tick && run_reg && ctl_reg.mode == MODE_CAP && cnt_reg != 10'h3ff
      |=> cnt_reg == $past(cnt_reg) + 10'h001;
  endproperty
  a_cap_ignore: assert property (p_cap_ignore) else $error("capture mode cleared counter");
  property p_init;
    run_rise |=> cmp_out_reg == $past(ctl_reg.output_level_control);
  endproperty
  a_init: assert property (p_init) else $error("pin not set to initial level");
  property p_hold;
    !run_rise && !(tick && run_reg && match_a) |=> $stable(cmp_out_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("compare pin changed without match");
  property p_invert;
    ctl_reg.mode == MODE_CMP ##1 ctl_reg.mode == MODE_CMP
      |-> timer_output_pin_a_o == ($past(cmp_out_reg) ^ $past(ctl_reg.output_invert));
  endproperty
  a_invert: assert property (p_invert) else $error("pin polarity wrong");
  property p_full_duty;
    ctl_reg.mode == MODE_PWM && ctl_reg.pin_action == 2'h2 &&
      {1'b0, duty_val} >= period_eff && !ctl_reg.output_invert
      |=> timer_output_pin_a_o == $past(ctl_reg.output_level_control);
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full duty not active");
  property p_timer_mode;
    ctl_reg.mode == MODE_TMR |=> !timer_output_pin_a_o && !timer_output_en_o;
  endproperty
  a_timer_mode: assert property (p_timer_mode) else $error("pin driven in timer mode");
  property p_hi_zero;
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `ADDR_CNT_HI
      |=> s_axi_rvalid_o && s_axi_rdata_o[31:2] == 30'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("high byte upper bits not zero");

endmodule

// *** hw/timer_cfg.svh ***
/*
  Register map, field positions and reset values of the standard timer block.
  Assumes inclusion by bare name from the package and the timer module.
*/
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

`define ADDR_RUN 8'h00
`define ADDR_CTL 8'h04
`define ADDR_CNT_LO 8'h08
`define ADDR_CNT_HI 8'h0c
`define ADDR_CMPA_LO 8'h10
`define ADDR_CMPA_HI 8'h14
`define ADDR_CMPP 8'h18

`define RUN_BIT 0
`define CTL_RST 8'h00
`define CMP_RST 10'h000
`define CNT_RST 10'h000
`define CNT_MAX 10'h3ff
`define PWM_FULL 11'h400

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** hw/timer_pkg.sv ***
/*
  Types shared by the standard timer block: mode and control layouts.
  Assumes the configuration header is on the include path.
*/
package timer_pkg;
  `include "timer_cfg.svh"

  typedef enum logic [1:0] {
    MODE_CMP = 2'h0,
    MODE_CAP = 2'h1,
    MODE_PWM = 2'h2,
    MODE_TMR = 2'h3
  } tmr_mode_t;

  // Bit layout of the control register, msb first.
  typedef struct packed {
    tmr_mode_t mode;
    logic [1:0] pin_action;
    logic output_level_control;
    logic output_invert;
    logic period_duty_swap;
    logic clear_source_select;
  } ctl_t;
endpackage

// *** verification/standard_timer_output_and_clear_control_tb.sv ***
/*
  Self-checking bench for the standard timer block: a PWM table, then reset,
  register access, compare output, clear sources and single pulse by hand.
  Assumes the timer package and configuration header are compiled first.
*/
`timescale 1ns/1ns
`include "timer_cfg.svh"
module standard_timer_output_and_clear_control_tb;
  import timer_pkg::*;

  typedef struct packed {
    ctl_t ctl;
    logic [9:0] p;
    logic [9:0] a;
    logic [4:0] hi;
  } pwm_row_t;

  // Expected high cycles on each pin out of 16 for a period of 4 ticks.
  localparam pwm_row_t rows[9] = '{
    '{ctl_t'(8'ha8), 10'h004, 10'h001, 5'h04},
    '{ctl_t'(8'ha0), 10'h004, 10'h001, 5'h0c},
    '{ctl_t'(8'hac), 10'h004, 10'h001, 5'h0c},
    '{ctl_t'(8'haa), 10'h001, 10'h004, 5'h04},
    '{ctl_t'(8'ha9), 10'h004, 10'h001, 5'h04},
    '{ctl_t'(8'ha8), 10'h004, 10'h005, 5'h10},
    '{ctl_t'(8'ha8), 10'h004, 10'h004, 5'h10},
    '{ctl_t'(8'h88), 10'h004, 10'h001, 5'h00},
    '{ctl_t'(8'h98), 10'h004, 10'h001, 5'h10}
  };

  logic clk = 1'b0;
  logic rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, pin_a, pin_b, pin_en;
  logic [1:0] bresp, rresp;
  int n_mismatch = 0;
  int checks = 0;

  always #5 clk = ~clk;

  standard_timer_output_and_clear_control #(.TICK_DIV(1)) dut_u (
    .ref_clk_i(clk), .rst_n_i(rst_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .timer_output_pin_a_o(pin_a), .timer_output_pin_b_o(pin_b),
    .timer_output_en_o(pin_en)
  );

  task automatic end_of_test();
    $display("Counts: %0d mismatches in %0d checks", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // A wait that used up its bound ends the run at once.
  task automatic hang(input int n, input int lim);
    if (n >= lim) begin
      n_mismatch++;
      $display("FAIL at %0t: wait ran out", $time);
      end_of_test();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok && n < 100) begin
      @(posedge clk);
      n++;
      if (!aw_ok && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (!w_ok && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
      if (bvalid === 1'b1) begin
        check(bresp, er);
        b_ok = 1'b1;
      end
    end
    hang(n, 100);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_ok;
    logic r_ok;
    n = 0;
    ar_ok = 1'b0;
    r_ok = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok && n < 100) begin
      @(posedge clk);
      n++;
      if (!ar_ok && arready === 1'b1) begin
        arvalid <= 1'b0;
        ar_ok = 1'b1;
      end else if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        r_ok = 1'b1;
      end
    end
    hang(n, 100);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, `RESP_OKAY);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    check(d, e);
    check(r, er);
  endtask

  // Stops the timer before touching control, as software must, then starts it.
  task automatic setup(input ctl_t c, input logic [9:0] p, input logic [9:0] a);
    wr(`ADDR_RUN, 32'h0);
    wr(`ADDR_CTL, {24'h0, c});
    wr(`ADDR_CMPP, {22'h0, p});
    wr(`ADDR_CMPA_LO, {24'h0, a[7:0]});
    wr(`ADDR_CMPA_HI, {30'h0, a[9:8]});
    wr(`ADDR_RUN, 32'h1);
    repeat (3) @(posedge clk);
  endtask

  task automatic wait_pin(input logic lvl, output int n);
    n = 0;
    while (pin_a !== lvl && n < 1200) begin
      @(posedge clk);
      n++;
    end
    hang(n, 1200);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    int hi;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    rst_n = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      setup(rows[i].ctl, rows[i].p, rows[i].a);
      repeat (9) @(posedge clk);
      hi = 0;
      repeat (16) begin
        @(posedge clk);
        hi += (pin_a === 1'b1) + (pin_b === 1'b1);
      end
      check(hi, 2 * rows[i].hi);
      check(pin_en, 1'b1);
    end
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    check({awready, wready, arready, bvalid, rvalid, pin_a, pin_en}, 7'h70);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a <= 'h18; a += 4) rd_chk(a[7:0], 32'h0, `RESP_OKAY);
    wr(`ADDR_CMPA_LO, 32'h1a5);
    rd_chk(`ADDR_CMPA_LO, 32'ha5, `RESP_OKAY);
    wr(`ADDR_CMPA_HI, 32'hff);
    rd_chk(`ADDR_CMPA_HI, 32'h3, `RESP_OKAY);
    wr(`ADDR_CNT_LO, 32'h55);
    wr(`ADDR_CNT_HI, 32'hff);
    rd_chk(`ADDR_CNT_LO, 32'h0, `RESP_OKAY);
    rd_chk(`ADDR_CNT_HI, 32'h0, `RESP_OKAY);
    axi_wr(8'h1c, 32'h1, `RESP_SLVERR);
    rd_chk(8'h1c, 32'h0, `RESP_SLVERR);
    for (int k = 0; k < 4; k++) begin
      setup(ctl_t'({4'h3, k[1:0], 2'b01}), 10'h000, 10'h200);
      check(pin_a, k[1] ^ k[0]);
      check(pin_en, 1'b1);
      wait_pin(!(k[1] ^ k[0]), n);
      check(n > 400, 1'b1);
      wr(`ADDR_RUN, 32'h0);
      wr(`ADDR_RUN, 32'h1);
      repeat (3) @(posedge clk);
      check(pin_a, k[1] ^ k[0]);
    end
    for (int j = 0; j < 2; j++) begin
      setup(ctl_t'(8'hcd - j[7:0]), 10'h008, 10'h010);
      check(pin_en, 1'b0);
      check(pin_a, 1'b0);
      // A counter left above the clear value must wrap once before it cycles.
      repeat (1030) @(posedge clk);
      repeat (6) begin
        axi_rd(`ADDR_CNT_LO, d, r);
        check(d <= (j == 0 ? 32'h10 : 32'h8), 1'b1);
      end
    end
    setup(ctl_t'(8'hcc), 10'h000, 10'h010);
    repeat (300) @(posedge clk);
    axi_rd(`ADDR_CNT_HI, d, r);
    check(d, 32'h1);
    repeat (800) @(posedge clk);
    axi_rd(`ADDR_CNT_HI, d, r);
    check(d, 32'h0);
    setup(ctl_t'(8'hb8), 10'h000, 10'h020);
    check(pin_a, 1'b1);
    wait_pin(1'b0, n);
    axi_rd(`ADDR_RUN, d, r);
    check(d, 32'h0);
    setup(ctl_t'(8'h40), 10'h030, 10'h3ff);
    check(pin_en, 1'b0);
    check(pin_a, 1'b0);
    repeat (40) @(posedge clk);
    axi_rd(`ADDR_CNT_LO, d, r);
    check(d > 32'h30, 1'b1);
    end_of_test();
  end
endmodule
